// ### inc/misc_pins_pkg.sv
// How it works
// - The serial clock level seen during bus reset marks ROM presence.
// - With a ROM present, the serial clock is made by pulling low only.
// - Serial data is only ever pulled low or released, never driven high.
// - Host speaker output is the XOR of all card speaker and audio inputs.
// - Under suspend, global or bus reset leaves internal registers alone.
// - Ring indicate and wake events share the one event output.
package misc_pins_pkg;

   // ------------------------------------------------------------------
   // Timing of the serial ROM clock.
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int SCL_QUARTER_NS  = 2500;
   localparam int SCL_QUARTER_CYC =
      (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QCNT_W          = 7;

   // ------------------------------------------------------------------
   // Serial ROM addressing and bit framing.
   // ------------------------------------------------------------------
   localparam logic [7:0] ROM_ADDR_WRITE   = 8'hA0;
   localparam logic [7:0] ROM_ADDR_READ    = 8'hA1;
   localparam logic [7:0] ROM_START_OFFSET = 8'h00;
   localparam logic [7:0] READ_FILL        = 8'hFF;
   localparam logic [3:0] LAST_BIT         = 4'h8;
   localparam logic       ACK_LEVEL        = 1'b0;
   localparam logic       NACK_LEVEL       = 1'b1;

   // Quarters of one serial bit.
   localparam logic [1:0] Q_SETUP  = 2'h0;
   localparam logic [1:0] Q_RISE   = 2'h1;
   localparam logic [1:0] Q_SAMPLE = 2'h2;
   localparam logic [1:0] Q_FALL   = 2'h3;

   // Steps of the ROM load program.
   localparam logic [2:0] STEP_START   = 3'h0;
   localparam logic [2:0] STEP_DEVW    = 3'h1;
   localparam logic [2:0] STEP_OFFS    = 3'h2;
   localparam logic [2:0] STEP_RESTART = 3'h3;
   localparam logic [2:0] STEP_DEVR    = 3'h4;
   localparam logic [2:0] STEP_READ    = 3'h5;

   // ------------------------------------------------------------------
   // Commands of the bit engine and states of the load sequencer.
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_START = 2'b00,
      CMD_STOP  = 2'b01,
      CMD_WRITE = 2'b10,
      CMD_READ  = 2'b11
   } cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_ISSUE     = 3'b001,
      ST_WAIT      = 3'b010,
      ST_STOP      = 3'b011,
      ST_STOP_WAIT = 3'b100
   } seq_t;

endpackage : misc_pins_pkg

// ### core/serial_rom_engine.sv
`timescale 1ns/10ps
module serial_rom_engine
   import misc_pins_pkg::*;
(
   input  wire logic       clk,       // Block clock.
   input  wire logic       rst,       // Synchronous reset, active high.
   input  wire logic       go,        // Start one command, one cycle.
   input  cmd_t            cmd,       // Command to run.
   input  wire logic [7:0] tx_byte,   // Byte to write.
   input  wire logic       ack_bit,   // Ack level sent after a read byte.
   input  wire logic       sda_level, // Synchronised data line level.
   output logic            busy,      // Command in progress.
   output logic            done,      // Command finished, one cycle.
   output logic [7:0]      rx_byte,   // Byte seen on the line.
   output logic            rx_ack,    // Ack level seen after the byte.
   output logic            scl_pull,  // Pull the clock line low.
   output logic            sda_pull   // Pull the data line low.
);

   typedef struct packed {
      logic              busy;
      logic              done;
      cmd_t              cmd;
      logic [QCNT_W-1:0] qcnt;
      logic [1:0]        phase;
      logic [3:0]        bitn;
      logic [8:0]        tx;
      logic [8:0]        rx;
      logic              scl_pull;
      logic              sda_pull;
   } eng_t;

   eng_t r;
   eng_t next_r;

   // Returns the clock and data pull for one quarter; lines only go low.
   function automatic logic [1:0] drive(cmd_t c, logic [1:0] ph, logic b);
      logic [1:0] p;
      p = 2'b00;
      case (c)
         CMD_START: begin
            case (ph)
               Q_SETUP:  p = 2'b10;
               Q_RISE:   p = 2'b00;
               Q_SAMPLE: p = 2'b01;
               default:  p = 2'b11;
            endcase
         end
         CMD_STOP: begin
            case (ph)
               Q_SETUP: p = 2'b11;
               Q_RISE:  p = 2'b01;
               default: p = 2'b00;
            endcase
         end
         default: begin
            case (ph)
               Q_RISE, Q_SAMPLE: p = {1'b0, ~b};
               default:          p = {1'b1, ~b};
            endcase
         end
      endcase
      return p;
   endfunction : drive

   // Steps each command through its bits, four quarters to a bit.
   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      if (!r.busy) begin
         if (go) begin
            next_r.busy  = 1'b1;
            next_r.cmd   = cmd;
            next_r.qcnt  = '0;
            next_r.phase = Q_SETUP;
            next_r.bitn  = '0;
            next_r.rx    = '0;
            next_r.tx    = (cmd == CMD_READ) ? {READ_FILL, ack_bit}
                                             : {tx_byte, NACK_LEVEL};
            {next_r.scl_pull, next_r.sda_pull} =
               drive(cmd, Q_SETUP, next_r.tx[8]);
         end
      end else if (r.qcnt != QCNT_W'(SCL_QUARTER_CYC - 1)) begin
         next_r.qcnt = r.qcnt + QCNT_W'(1);
      end else begin
         next_r.qcnt = '0;
         if (r.phase == Q_SAMPLE && r.cmd[1]) begin
            next_r.rx = {r.rx[7:0], sda_level};
         end
         if (r.phase == Q_FALL) begin
            if (r.cmd[1] && r.bitn != LAST_BIT) begin
               next_r.bitn  = r.bitn + 4'h1;
               next_r.tx    = {r.tx[7:0], NACK_LEVEL};
               next_r.phase = Q_SETUP;
               {next_r.scl_pull, next_r.sda_pull} =
                  drive(r.cmd, Q_SETUP, r.tx[7]);
            end else begin
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
            end
         end else begin
            next_r.phase = r.phase + 2'h1;
            {next_r.scl_pull, next_r.sda_pull} =
               drive(r.cmd, r.phase + 2'h1, r.tx[8]);
         end
      end
   end

   // Registers the engine state.
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign busy     = r.busy;
   assign done     = r.done;
   assign rx_byte  = r.rx[8:1];
   assign rx_ack   = r.rx[0];
   assign scl_pull = r.scl_pull;
   assign sda_pull = r.sda_pull;

endmodule : serial_rom_engine

// ### core/misc_control_pins.sv
`timescale 1ns/10ps
module misc_control_pins
   import misc_pins_pkg::*;
#(
   parameter int SOCKETS   = 2,  // Number of card sockets.
   parameter int ROM_BYTES = 16  // Bytes loaded from the serial ROM.
)(
   input  wire logic         CLOCK,                 // Block clock.
   input  wire logic         SYS_RST,               // Power-on reset.
   input  wire logic         HOST_BUS_RESET_IN_N,   // Host bus reset.
   input  wire logic         GLOBAL_RESET_IN_N,     // Global reset.
   input  wire logic         SUSPEND_IN,            // Suspend request.
   input  wire logic         SCL_IN,                // Clock line level.
   output logic              SCL_OUT,               // Clock drive level.
   output logic              SCL_OE,                // Clock pull enable.
   input  wire logic         SDA_IN,                // Data line level.
   output logic              SDA_OUT,               // Data drive level.
   output logic              SDA_OE,                // Data pull enable.
   input  wire logic [SOCKETS-1:0] CARD_SPEAKER_IN,       // Card speaker.
   input  wire logic [SOCKETS-1:0] CARD_DIGITAL_AUDIO_IN, // Card audio.
   output logic              HOST_SPEAKER_OUT,      // Host speaker.
   input  wire logic [SOCKETS-1:0] RING_EVENT_IN,   // Card ring events.
   input  wire logic         WAKE_EVENT_IN,         // Wake event.
   output logic              RING_WAKE_EVENT_OUT,   // Shared event out.
   output logic              ROM_PRESENT,           // ROM found at reset.
   output logic              ROM_LOAD_DONE,         // ROM load finished.
   output logic              ROM_LOAD_ERROR,        // ROM did not ack.
   input  wire logic [((ROM_BYTES > 1) ? $clog2(ROM_BYTES) : 1)-1:0]
                             ROM_BYTE_ADDR,         // Loaded byte index.
   output logic [7:0]        ROM_BYTE_DATA          // Loaded byte value.
);

   localparam int IDX_W = (ROM_BYTES > 1) ? $clog2(ROM_BYTES) : 1;
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ROM_BYTES - 1);

   // ------------------------------------------------------------------
   // Block state.
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]               bus_rst_s;
      logic [1:0]               glob_rst_s;
      logic [1:0]               susp_s;
      logic [1:0]               scl_s;
      logic [1:0]               sda_s;
      logic [SOCKETS-1:0]       spk_s0;
      logic [SOCKETS-1:0]       spk_s1;
      logic [SOCKETS-1:0]       aud_s0;
      logic [SOCKETS-1:0]       aud_s1;
      logic [SOCKETS-1:0]       ring_s0;
      logic [SOCKETS-1:0]       ring_s1;
      logic [1:0]               wake_s;
      logic                     clear_q;
      logic                     rom_present;
      seq_t                     state;
      logic [2:0]               step;
      logic [IDX_W-1:0]         idx;
      logic                     load_done;
      logic                     load_err;
      logic [ROM_BYTES-1:0][7:0] mem;
      logic                     eng_go;
      cmd_t                     eng_cmd;
      logic [7:0]               eng_tx;
      logic                     eng_ack;
      logic                     scl_oe;
      logic                     sda_oe;
      logic                     pin_low;
      logic                     spk_out;
      logic                     event_out;
      logic [7:0]               data_out;
   } top_t;

   top_t r;
   top_t next_r;

   logic       eng_rst;
   logic       eng_busy;
   logic       eng_done;
   logic [7:0] eng_rx;
   logic       eng_rx_ack;
   logic       eng_scl_pull;
   logic       eng_sda_pull;
   logic       clear;

   // The engine is held in reset while internal registers are cleared,
   // so a bus reset releases both lines at once.
   assign eng_rst = SYS_RST | r.clear_q;

   // ------------------------------------------------------------------
   // Serial ROM bit engine.
   // ------------------------------------------------------------------
   serial_rom_engine u_engine (
      .clk       (CLOCK),
      .rst       (eng_rst),
      .go        (r.eng_go),
      .cmd       (r.eng_cmd),
      .tx_byte   (r.eng_tx),
      .ack_bit   (r.eng_ack),
      .sda_level (r.sda_s[1]),
      .busy      (eng_busy),
      .done      (eng_done),
      .rx_byte   (eng_rx),
      .rx_ack    (eng_rx_ack),
      .scl_pull  (eng_scl_pull),
      .sda_pull  (eng_sda_pull)
   );

   // ------------------------------------------------------------------
   // Next state.
   // ------------------------------------------------------------------

   // Clearing happens under either reset unless suspend protects it.
   assign clear = (~r.bus_rst_s[1] | ~r.glob_rst_s[1]) & ~r.susp_s[1];

   always_comb begin
      next_r        = r;
      next_r.eng_go = 1'b0;

      // Two-stage synchronisers for every pin input but SYS_RST and ROM_BYTE_ADDR.
      next_r.bus_rst_s  = {r.bus_rst_s[0], HOST_BUS_RESET_IN_N};
      next_r.glob_rst_s = {r.glob_rst_s[0], GLOBAL_RESET_IN_N};
      next_r.susp_s  = {r.susp_s[0], SUSPEND_IN};
      next_r.scl_s   = {r.scl_s[0], SCL_IN};
      next_r.sda_s   = {r.sda_s[0], SDA_IN};
      next_r.spk_s0  = CARD_SPEAKER_IN;
      next_r.spk_s1  = r.spk_s0;
      next_r.aud_s0  = CARD_DIGITAL_AUDIO_IN;
      next_r.aud_s1  = r.aud_s0;
      next_r.ring_s0 = RING_EVENT_IN;
      next_r.ring_s1 = r.ring_s0;
      next_r.wake_s  = {r.wake_s[0], WAKE_EVENT_IN};
      next_r.clear_q = clear;

      // Load sequencer: offset write, repeated start, sequential read.
      case (r.state)
         ST_IDLE: begin
            // The strap is taken once more as the reset ends: at power-on
            // the pin level and the reset release cross the synchronisers
            // together, so the clear cycles alone would miss it.
            if (r.clear_q && !clear && !r.susp_s[1]) begin
               next_r.rom_present = r.scl_s[1];
            end
            if (r.clear_q && !clear && !r.susp_s[1] && r.scl_s[1]) begin
               next_r.state     = ST_ISSUE;
               next_r.step      = STEP_START;
               next_r.idx       = '0;
               next_r.load_done = 1'b0;
               next_r.load_err  = 1'b0;
            end
         end
         ST_ISSUE: begin
            if (!eng_busy) begin
               next_r.eng_go = 1'b1;
               next_r.eng_tx = ROM_START_OFFSET;
               next_r.eng_ack = (r.idx == LAST_IDX) ? NACK_LEVEL : ACK_LEVEL;
               case (r.step)
                  STEP_START, STEP_RESTART: next_r.eng_cmd = CMD_START;
                  STEP_DEVW: begin
                     next_r.eng_cmd = CMD_WRITE;
                     next_r.eng_tx  = ROM_ADDR_WRITE;
                  end
                  STEP_OFFS:  next_r.eng_cmd = CMD_WRITE;
                  STEP_DEVR: begin
                     next_r.eng_cmd = CMD_WRITE;
                     next_r.eng_tx  = ROM_ADDR_READ;
                  end
                  default:    next_r.eng_cmd = CMD_READ;
               endcase
               next_r.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (eng_done) begin
               next_r.state = ST_ISSUE;
               case (r.step)
                  STEP_DEVW, STEP_OFFS, STEP_DEVR: begin
                     if (eng_rx_ack == NACK_LEVEL) begin
                        next_r.load_err = 1'b1;
                        next_r.state    = ST_STOP;
                     end else begin
                        next_r.step = r.step + 3'h1;
                     end
                  end
                  STEP_READ: begin
                     next_r.mem[r.idx] = eng_rx;
                     if (r.idx == LAST_IDX) begin
                        next_r.state = ST_STOP;
                     end else begin
                        next_r.idx = r.idx + IDX_W'(1);
                     end
                  end
                  default: next_r.step = r.step + 3'h1;
               endcase
            end
         end
         ST_STOP: begin
            if (!eng_busy) begin
               next_r.eng_go  = 1'b1;
               next_r.eng_cmd = CMD_STOP;
               next_r.state   = ST_STOP_WAIT;
            end
         end
         ST_STOP_WAIT: begin
            if (eng_done) begin
               next_r.load_done = 1'b1;
               next_r.state     = ST_IDLE;
            end
         end
         default: next_r.state = ST_IDLE;
      endcase

      // Reset clears the registers and samples the strap on the clock pin.
      if (clear) begin
         next_r.rom_present = r.scl_s[1];
         next_r.state       = ST_IDLE;
         next_r.step        = STEP_START;
         next_r.idx         = '0;
         next_r.load_done   = 1'b0;
         next_r.load_err    = 1'b0;
         next_r.mem         = '0;
         next_r.eng_go      = 1'b0;
      end

      // Pins are only ever pulled low, and only with a ROM present.
      next_r.pin_low = 1'b0;
      next_r.scl_oe  = eng_scl_pull & r.rom_present & ~r.clear_q;
      next_r.sda_oe  = eng_sda_pull & r.rom_present & ~r.clear_q;

      // Speaker mixing and the shared event output.
      next_r.spk_out   = ^{r.spk_s1, r.aud_s1};
      next_r.event_out = |{r.ring_s1, r.wake_s[1]};
      next_r.data_out  = r.mem[ROM_BYTE_ADDR];
   end

   // ------------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------------

   // Registers all block state on every rising clock edge.
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------------

   // Every output comes straight from a state flip-flop.
   assign SCL_OUT             = r.pin_low;
   assign SCL_OE              = r.scl_oe;
   assign SDA_OUT             = r.pin_low;
   assign SDA_OE              = r.sda_oe;
   assign HOST_SPEAKER_OUT    = r.spk_out;
   assign RING_WAKE_EVENT_OUT = r.event_out;
   assign ROM_PRESENT         = r.rom_present;
   assign ROM_LOAD_DONE       = r.load_done;
   assign ROM_LOAD_ERROR      = r.load_err;
   assign ROM_BYTE_DATA       = r.data_out;

endmodule : misc_control_pins

// ### verif/misc_control_pins_chk.sv
`timescale 1ns/10ps
module misc_control_pins_chk
   import misc_pins_pkg::*;
#(
   parameter int SOCKETS = 2  // Number of card sockets.
)(
   input wire logic               CLOCK,                 // Block clock.
   input wire logic               SYS_RST,               // Power-on reset.
   input wire logic               HOST_BUS_RESET_IN_N,   // Bus reset.
   input wire logic               GLOBAL_RESET_IN_N,     // Global reset.
   input wire logic               SUSPEND_IN,            // Suspend.
   input wire logic               SCL_IN,                // Clock line.
   input wire logic               SCL_OUT,               // Clock drive.
   input wire logic               SCL_OE,                // Clock pull.
   input wire logic               SDA_OUT,               // Data drive.
   input wire logic               SDA_OE,                // Data pull.
   input wire logic [SOCKETS-1:0] CARD_SPEAKER_IN,       // Card speaker.
   input wire logic [SOCKETS-1:0] CARD_DIGITAL_AUDIO_IN, // Card audio.
   input wire logic               HOST_SPEAKER_OUT,      // Host speaker.
   input wire logic [SOCKETS-1:0] RING_EVENT_IN,         // Ring events.
   input wire logic               WAKE_EVENT_IN,         // Wake event.
   input wire logic               RING_WAKE_EVENT_OUT,   // Event out.
   input wire logic               ROM_PRESENT            // Strap result.
);
   // ------------------------------------------------------------------
   // Pin relations, all in the block clock domain.
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   a_spk_parity: assert property (
      ($stable(CARD_SPEAKER_IN) && $stable(CARD_DIGITAL_AUDIO_IN))[*4]
      |-> HOST_SPEAKER_OUT == ^{CARD_SPEAKER_IN, CARD_DIGITAL_AUDIO_IN})
      else $error("speaker output is not the input parity");
   a_event_merge: assert property (
      ($stable(RING_EVENT_IN) && $stable(WAKE_EVENT_IN))[*4]
      |-> RING_WAKE_EVENT_OUT == ((|RING_EVENT_IN) | WAKE_EVENT_IN))
      else $error("event output does not merge the events");
   a_drive_low_only: assert property (
      !SCL_OUT && !SDA_OUT)
      else $error("a serial line is driven high");
   a_quiet_no_rom: assert property (
      (!ROM_PRESENT)[*2] |-> !SCL_OE && !SDA_OE)
      else $error("serial line pulled without a ROM");
   a_scl_low_hold: assert property (
      disable iff (SYS_RST || !HOST_BUS_RESET_IN_N || !GLOBAL_RESET_IN_N)
      $rose(SCL_OE) |-> SCL_OE[*8])
      else $error("serial clock low phase too short");
   a_scl_high_hold: assert property (
      disable iff (SYS_RST || !HOST_BUS_RESET_IN_N || !GLOBAL_RESET_IN_N)
      $fell(SCL_OE) |-> (!SCL_OE)[*8])
      else $error("serial clock high phase too short");
   a_strap_sample: assert property (
      (!HOST_BUS_RESET_IN_N && !SUSPEND_IN && $stable(SCL_IN))[*5]
      |-> ROM_PRESENT == SCL_IN)
      else $error("presence does not follow the clock strap");
   a_suspend_keep: assert property (
      SUSPEND_IN[*4] |=> $stable(ROM_PRESENT))
      else $error("presence changed while suspended");
endmodule : misc_control_pins_chk

bind misc_control_pins misc_control_pins_chk #(.SOCKETS(SOCKETS)) i_chk (
   .CLOCK(CLOCK), .SYS_RST(SYS_RST), .SUSPEND_IN(SUSPEND_IN),
   .HOST_BUS_RESET_IN_N(HOST_BUS_RESET_IN_N),
   .GLOBAL_RESET_IN_N(GLOBAL_RESET_IN_N), .SCL_IN(SCL_IN),
   .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .CARD_SPEAKER_IN(CARD_SPEAKER_IN), .HOST_SPEAKER_OUT(HOST_SPEAKER_OUT),
   .CARD_DIGITAL_AUDIO_IN(CARD_DIGITAL_AUDIO_IN),
   .RING_EVENT_IN(RING_EVENT_IN), .WAKE_EVENT_IN(WAKE_EVENT_IN),
   .RING_WAKE_EVENT_OUT(RING_WAKE_EVENT_OUT), .ROM_PRESENT(ROM_PRESENT));

// ### verif/serial_rom_model.sv
`timescale 1ns/10ps
module serial_rom_model (
   input  wire logic scl,      // Clock line level.
   input  wire logic sda,      // Data line level.
   input  wire logic refuse,   // Nack every device address.
   output logic      sda_pull  // Pull the data line low.
);
   logic [7:0] shreg;
   logic [7:0] ptr;
   int         bitn;
   logic       active = 1'b0;
   logic       addr_ph;
   logic       rd;
   logic       mack;
   logic       ok;

   // The model starts with the data line released.
   initial sda_pull = 1'b0;

   // Data falling while the clock is high opens a transfer.
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         active  = 1'b1;
         addr_ph = 1'b1;
         rd      = 1'b0;
         bitn    = 0;
      end
   end

   // Data rising while the clock is high ends it and lets the line go.
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         active   = 1'b0;
         sda_pull = 1'b0;
      end
   end

   // Bits and the host acknowledge are taken while the clock is high.
   always @(posedge scl) begin
      if (active) begin
         if (bitn < 8 && !rd) begin
            shreg = {shreg[6:0], sda};
         end
         if (bitn == 8 && rd) begin
            mack = sda;
         end
         bitn++;
      end
   end

   // The model moves the data line only while the clock is low.
   always @(negedge scl) begin
      if (active && bitn == 8 && !rd) begin
         ok = !addr_ph || (!refuse && shreg[7:1] == 7'h50);
         sda_pull = ok;
         active = ok;
         if (addr_ph) begin
            rd = shreg[0];
         end else begin
            ptr = shreg;
         end
         addr_ph = 1'b0;
         mack = 1'b0;
      end else if (active && bitn == 8) begin
         sda_pull = 1'b0;
         ptr = ptr + 8'h01;
      end else if (active) begin
         if (bitn == 9) begin
            bitn = 0;
         end
         if (rd && bitn == 0) begin
            shreg = {ptr[3:0], ~ptr[3:0]};
         end
         sda_pull = rd && !mack && !shreg[7 - bitn];
      end
   end
endmodule : serial_rom_model

// ### verif/misc_control_pins_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp); \
   end \
end
module misc_control_pins_tb;
   logic       clock, sys_rst, bus_rst_n, glob_rst_n, suspend;
   logic       scl_out, scl_oe, sda_out, sda_oe, rom_pull, pull_hi, refuse;
   logic       spk_out, evt_out, wake, present, done, load_err;
   logic [1:0] spk, aud, ring;
   logic [3:0] byte_addr;
   logic [7:0] byte_data;
   int         num_errors = 0;
   int         n_tests = 0;
   // The lines idle at the strap level unless a party pulls them low.
   wire scl_w = scl_oe ? scl_out : pull_hi;
   wire sda_w = sda_oe ? sda_out : (rom_pull ? 1'b0 : pull_hi);

   misc_control_pins #(.SOCKETS(2), .ROM_BYTES(16)) i_dut (
      .CLOCK(clock), .SYS_RST(sys_rst), .HOST_BUS_RESET_IN_N(bus_rst_n),
      .GLOBAL_RESET_IN_N(glob_rst_n), .SUSPEND_IN(suspend),
      .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
      .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
      .CARD_SPEAKER_IN(spk), .CARD_DIGITAL_AUDIO_IN(aud),
      .HOST_SPEAKER_OUT(spk_out), .RING_EVENT_IN(ring),
      .WAKE_EVENT_IN(wake), .RING_WAKE_EVENT_OUT(evt_out),
      .ROM_PRESENT(present), .ROM_LOAD_DONE(done),
      .ROM_LOAD_ERROR(load_err), .ROM_BYTE_ADDR(byte_addr),
      .ROM_BYTE_DATA(byte_data));
   serial_rom_model i_rom (
      .scl(scl_w), .sda(sda_w), .refuse(refuse), .sda_pull(rom_pull));

   // ------------------------------------------------------------------
   // Shared helpers.
   // ------------------------------------------------------------------
   task automatic cycles(input int n);
      repeat (n) @(negedge clock);
   endtask : cycles

   task automatic pulse_reset(input logic bus, input int n);
      if (bus) begin
         bus_rst_n = 1'b0;
      end else begin
         glob_rst_n = 1'b0;
      end
      cycles(n);
      bus_rst_n = 1'b1;
      glob_rst_n = 1'b1;
      cycles(6);
   endtask : pulse_reset

   task automatic wait_done(input int lim);
      for (int i = 0; i < lim && done !== 1'b1; i++) begin
         cycles(1);
      end
   endtask : wait_done

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   // ------------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------------
   task automatic t_power_load;
      wait_done(50000);
      `CHK(done, 1'b1)
      `CHK(present, 1'b1)
      `CHK(load_err, 1'b0)
      for (int k = 0; k < 16; k++) begin
         byte_addr = k[3:0];
         cycles(2);
         `CHK(byte_data, {k[3:0], ~k[3:0]})
      end
   endtask : t_power_load

   task automatic t_outputs;
      for (int v = 0; v < 16; v++) begin
         {spk, aud} = v[3:0];
         {ring, wake} = v[2:0];
         cycles(5);
         `CHK(spk_out, ^v[3:0])
         `CHK(evt_out, |v[2:0])
      end
   endtask : t_outputs

   task automatic t_suspend;
      suspend = 1'b1;
      cycles(4);
      pull_hi = 1'b0;
      pulse_reset(1'b1, 8);
      pulse_reset(1'b0, 8);
      `CHK(present, 1'b1)
      `CHK(done, 1'b1)
      byte_addr = 4'h9;
      cycles(2);
      `CHK(byte_data, 8'h96)
      pull_hi = 1'b1;
      suspend = 1'b0;
      cycles(4);
   endtask : t_suspend

   task automatic t_refused;
      refuse = 1'b1;
      pulse_reset(1'b0, 5);
      wait_done(8000);
      `CHK(load_err, 1'b1)
      `CHK(present, 1'b1)
      refuse = 1'b0;
   endtask : t_refused

   task automatic t_no_rom;
      logic oe_any;
      oe_any = 1'b0;
      pull_hi = 1'b0;
      pulse_reset(1'b1, 8);
      repeat (1500) begin
         cycles(1);
         oe_any = oe_any | scl_oe | sda_oe;
      end
      `CHK(present, 1'b0)
      `CHK(oe_any, 1'b0)
      `CHK(done, 1'b0)
   endtask : t_no_rom

   // Free-running 25 MHz block clock.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Cuts a hung run short well past the expected length.
   initial begin
      #(100000 * 40);
      num_errors++;
      close_out();
   end

   // Main sequence.
   initial begin
      {sys_rst, bus_rst_n, glob_rst_n, pull_hi} = 4'hF;
      {suspend, refuse, wake} = 3'h0;
      {spk, aud, ring} = 6'h00;
      byte_addr = 4'h0;
      cycles(10);
      sys_rst = 1'b0;
      t_power_load();
      t_outputs();
      t_suspend();
      t_refused();
      t_no_rom();
      close_out();
   end
endmodule : misc_control_pins_tb
